// file: design/breakpoint_debug_status.sv
// breakpoint address registers, alias slots, control and event status
// assumes the core issues one move or one event group per cycle, synchronous to i_mclk
module breakpoint_debug_status
  import dbg_pkg::*;
#(
  parameter int  NUM_BP      = 4,
  parameter bit  EIGHT_BYTE  = 1'b1
) (
  // clock and reset
  input  wire logic        i_mclk,
  input  wire logic        i_reset_n,
  // processor mode
  input  wire logic        i_real_mode,
  input  wire logic        i_mgmt_state,
  input  wire logic [1:0]  i_priv_level,
  input  wire logic        i_ext_flag,
  input  wire logic        i_txn_debug,
  // debug register move
  input  wire logic        i_mov_req,
  input  wire logic        i_mov_write,
  input  wire logic [2:0]  i_mov_slot,
  input  wire logic [31:0] i_mov_wdata,
  // retired access or instruction
  input  wire logic        i_acc_valid,
  input  wire logic [1:0]  i_acc_kind,
  input  wire logic [31:0] i_acc_addr,
  input  wire logic [3:0]  i_acc_len,
  input  wire logic        i_insn_done,
  input  wire logic        i_step_flag,
  input  wire logic        i_resume_flag,
  input  wire logic        i_task_switch,
  input  wire logic        i_task_trap,
  input  wire logic        i_soft_break,
  // results
  output logic             o_mov_done,
  output logic [31:0]      o_mov_rdata,
  output logic             o_prot_fault,
  output logic             o_bad_opcode,
  output logic             o_debug_trap,
  output logic             o_soft_break_trap,
  output logic [31:0]      o_status
);
  // ----------------------------------------------------------------
  // reset release
  // ----------------------------------------------------------------
  logic rst_meta;
  logic rst_n;
  always_ff @(posedge i_mclk or negedge i_reset_n) begin
    if (!i_reset_n) begin
      rst_meta <= 1'b0;
      rst_n    <= 1'b0;
    end else begin
      rst_meta <= 1'b1;
      rst_n    <= rst_meta;
    end
  end

  // ----------------------------------------------------------------
  // storage
  // ----------------------------------------------------------------
  logic [31:0] break_addr [NUM_BP];
  logic [31:0] break_control_reg;
  logic [31:0] event_status_reg;
  state_t      state;
  state_t      next_state;

  // ----------------------------------------------------------------
  // move decode
  // ----------------------------------------------------------------
  wire mov_allowed = i_real_mode | i_mgmt_state | (i_priv_level == PRIV_TOP);
  wire alias_slot  = (i_mov_slot == SLOT_FOUR) | (i_mov_slot == SLOT_FIVE);
  wire guard_on    = break_control_reg[CTRL_GUARD];
  wire guard_trap  = i_mov_req & guard_on;
  wire mov_gp      = i_mov_req & ~guard_on & ~mov_allowed;
  wire mov_ud      = i_mov_req & ~guard_on & mov_allowed & alias_slot & i_ext_flag;
  wire mov_ok      = i_mov_req & ~guard_on & ~mov_gp & ~mov_ud;
  // slots four and five fold onto status and control when extensions are off
  wire [2:0] eff_slot = alias_slot ? (i_mov_slot | 3'h2) : i_mov_slot;
  wire wr_addr     = mov_ok & i_mov_write & (eff_slot <= SLOT_ADDR3);
  wire wr_status   = mov_ok & i_mov_write & (eff_slot == SLOT_STATUS);
  wire wr_ctrl     = mov_ok & i_mov_write & (eff_slot == SLOT_CTRL);

  // ----------------------------------------------------------------
  // breakpoint match, one comparator per breakpoint
  // ----------------------------------------------------------------
  logic [NUM_BP-1:0] cond_hit;
  logic [NUM_BP-1:0] bp_enabled;
  genvar g;
  generate
    for (g = 0; g < NUM_BP; g++) begin : g_bp
      wire [1:0]  kind = break_control_reg[KIND_LSB + 4*g +: 2];
      wire [1:0]  span = break_control_reg[KIND_LSB + 4*g + 2 +: 2];
      // span masks the low address bits of the watched location
      wire [31:0] mask = (span == SPAN_2) ? 32'hFFFFFFFE :
                         (span == SPAN_4) ? 32'hFFFFFFFC :
                         (span == SPAN_8 && EIGHT_BYTE) ? 32'hFFFFFFF8 : 32'hFFFFFFFF;
      // access covers any byte of the watched range, linear compare
      wire [31:0] acc_end = i_acc_addr + {28'h0000000, i_acc_len} - 32'h00000001;
      wire        overlap = ((i_acc_addr & mask) <= (break_addr[g] & mask)) &&
                            ((acc_end & mask) >= (break_addr[g] & mask));
      // kind decode; i/o only meaningful with extensions on
      wire kind_ok = (kind == KIND_EXEC)  ? (i_acc_kind == KIND_EXEC) :
                     (kind == KIND_WRITE) ? (i_acc_kind == KIND_WRITE) :
                     (kind == KIND_IO)    ? (i_ext_flag && i_acc_kind == KIND_IO) :
                     ((i_acc_kind == KIND_WRITE) || (i_acc_kind == KIND_RDWR));
      // exec breakpoints are dropped on a resumed instruction
      assign cond_hit[g]   = i_acc_valid & kind_ok & overlap &
                             ~((kind == KIND_EXEC) & i_resume_flag);
      assign bp_enabled[g] = break_control_reg[2*g] | break_control_reg[2*g+1];
    end
  endgenerate

  // ----------------------------------------------------------------
  // trap causes
  // ----------------------------------------------------------------
  wire step_ev  = i_insn_done & i_step_flag;
  wire task_ev  = i_task_switch & i_task_trap;
  wire bp_ev    = |(cond_hit & bp_enabled);
  // any cause raises the one trap; the causes are ORed with no priority between them
  wire trap_now = step_ev | guard_trap | bp_ev | task_ev;

  // hit bits and transaction flag rewritten with the trap; cause bits only set
  logic [31:0] next_status;
  always_comb begin
    next_status = event_status_reg;
    if (trap_now) begin
      next_status[HIT_LSB +: NUM_BP] = cond_hit;
      if (step_ev) next_status[STEP_HIT] = 1'b1;
      if (guard_trap) next_status[REG_HIT] = 1'b1;
      if (task_ev) next_status[TASK_HIT] = 1'b1;
      // cleared only inside a debugged transaction
      next_status[TXN_BIT] = ~(i_txn_debug & break_control_reg[CTRL_TXN]);
    end else if (wr_status) begin
      next_status = i_mov_wdata;
    end
  end

  // ----------------------------------------------------------------
  // registers
  // ----------------------------------------------------------------
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      event_status_reg <= STATUS_RST;
    end else begin
      event_status_reg <= next_status;
    end
  end

  // control: guard clears on trap entry, local enables clear on task switch
  logic [31:0] next_ctrl;
  always_comb begin
    next_ctrl = wr_ctrl ? i_mov_wdata : break_control_reg;
    if (i_task_switch) next_ctrl = next_ctrl & 32'hFFFFFFAA;
    if (trap_now) next_ctrl[CTRL_GUARD] = 1'b0;
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      break_control_reg <= CTRL_RST;
    end else begin
      break_control_reg <= next_ctrl;
    end
  end

  // address registers written by moves
  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      for (int i = 0; i < NUM_BP; i++) break_addr[i] <= ADDR_RST;
    end else if (wr_addr && (32'(eff_slot) < NUM_BP)) begin
      break_addr[eff_slot[1:0]] <= i_mov_wdata;
    end
  end

  // ----------------------------------------------------------------
  // read data and results
  // ----------------------------------------------------------------
  wire [31:0] rd_mux = (eff_slot == SLOT_STATUS) ? event_status_reg :
                       (eff_slot == SLOT_CTRL)   ? break_control_reg :
                       (32'(eff_slot) < NUM_BP)  ? break_addr[eff_slot[1:0]] : 32'h00000000;

  // the hold state follows each cycle with a trap and stays while traps continue
  always_comb begin
    case (state)
      ST_IDLE: next_state = trap_now ? ST_HOLD : ST_IDLE;
      ST_HOLD: next_state = trap_now ? ST_HOLD : ST_IDLE;
      default: next_state = ST_IDLE;
    endcase
  end

  always_ff @(posedge i_mclk or negedge rst_n) begin
    if (!rst_n) begin
      state             <= ST_IDLE;
      o_mov_done        <= 1'b0;
      o_mov_rdata       <= 32'h00000000;
      o_prot_fault      <= 1'b0;
      o_bad_opcode      <= 1'b0;
      o_soft_break_trap <= 1'b0;
    end else begin
      state             <= next_state;
      o_mov_done        <= mov_ok;
      o_mov_rdata       <= (mov_ok && !i_mov_write) ? rd_mux : 32'h00000000;
      o_prot_fault      <= mov_gp;
      o_bad_opcode      <= mov_ud;
      o_soft_break_trap <= i_soft_break;
    end
  end

  assign o_debug_trap = (state == ST_HOLD);
  assign o_status     = event_status_reg;
endmodule

// file: design/dbg_pkg.sv
// debug breakpoint and event status constants
// assumes a core that presents one retired instruction or access per cycle
package dbg_pkg;
  // register slot numbers for the move instructions
  localparam logic [2:0] SLOT_ADDR0  = 3'h0;
  localparam logic [2:0] SLOT_ADDR3  = 3'h3;
  localparam logic [2:0] SLOT_FOUR   = 3'h4;
  localparam logic [2:0] SLOT_FIVE   = 3'h5;
  localparam logic [2:0] SLOT_STATUS = 3'h6;
  localparam logic [2:0] SLOT_CTRL   = 3'h7;
  // event status field positions
  localparam int HIT_LSB    = 0;
  localparam int REG_HIT    = 13;
  localparam int STEP_HIT   = 14;
  localparam int TASK_HIT   = 15;
  localparam int TXN_BIT    = 16;
  // control field positions
  localparam int CTRL_TXN   = 11;
  localparam int CTRL_GUARD = 13;
  localparam int KIND_LSB   = 16;
  // reset values
  localparam logic [31:0] STATUS_RST = 32'hFFFF0FF0;
  localparam logic [31:0] CTRL_RST   = 32'h00000400;
  localparam logic [31:0] ADDR_RST   = 32'h00000000;
  // access kind codes
  localparam logic [1:0] KIND_EXEC  = 2'h0;
  localparam logic [1:0] KIND_WRITE = 2'h1;
  localparam logic [1:0] KIND_IO    = 2'h2;
  localparam logic [1:0] KIND_RDWR  = 2'h3;
  // span codes
  localparam logic [1:0] SPAN_1 = 2'h0;
  localparam logic [1:0] SPAN_2 = 2'h1;
  localparam logic [1:0] SPAN_8 = 2'h2;
  localparam logic [1:0] SPAN_4 = 2'h3;
  // privilege level allowed to move debug registers
  localparam logic [1:0] PRIV_TOP = 2'h0;
  // checker states
  typedef enum logic [1:0] {
    ST_IDLE = 2'b01,
    ST_HOLD = 2'b10
  } state_t;
endpackage

// file: tb/bds_asserts.sv
// concurrent checks on the debug status block ports
// assumes bind to breakpoint_debug_status, single clock i_mclk
module bds_asserts (
  input wire logic        i_mclk,
  input wire logic        i_reset_n,
  input wire logic        i_txn_debug,
  input wire logic        i_real_mode,
  input wire logic        i_mgmt_state,
  input wire logic [1:0]  i_priv_level,
  input wire logic        i_ext_flag,
  input wire logic        i_mov_req,
  input wire logic        i_mov_write,
  input wire logic [2:0]  i_mov_slot,
  input wire logic        i_insn_done,
  input wire logic        i_step_flag,
  input wire logic        i_task_switch,
  input wire logic        i_task_trap,
  input wire logic        i_soft_break,
  input wire logic        o_mov_done,
  input wire logic        o_debug_trap,
  input wire logic        o_soft_break_trap,
  input wire logic [31:0] o_status
);
  default clocking @(posedge i_mclk); endclocking
  default disable iff (!i_reset_n);
  // ------------------------------------------------------------
  // properties
  // ------------------------------------------------------------
  priv_block_a: assert property (i_mov_req && !i_real_mode && !i_mgmt_state
    && i_priv_level != 2'h0 |=> !o_mov_done) else $error("move done at low privilege");
  slot_fault_a: assert property (i_mov_req && i_ext_flag && i_mov_slot inside {3'h4, 3'h5}
    |=> !o_mov_done) else $error("reserved slot move completed");
  status_cause_a: assert property ($changed(o_status) |-> o_debug_trap
    || $past(i_mov_req && i_mov_write)) else $error("status changed without trap");
  step_trap_a: assert property (i_insn_done && i_step_flag
    |=> o_debug_trap && o_status[14]) else $error("no step trap");
  task_trap_a: assert property (i_task_switch && i_task_trap
    |=> o_debug_trap && o_status[15]) else $error("no task switch trap");
  soft_break_a: assert property (i_soft_break |=> o_soft_break_trap)
    else $error("no soft break trap");
  // outside a transaction the flag must read set; the inside case depends on control bit 11
  txn_flag_a: assert property (o_debug_trap && !$past(i_txn_debug) |-> o_status[16])
    else $error("transaction flag wrong");
  sticky_bits_a: assert property (|($past(o_status[15:13]) & ~o_status[15:13])
    |-> $past(i_mov_req && i_mov_write)) else $error("status bit cleared by device");
  cover property (o_debug_trap && o_status[14]);
  cover property (o_debug_trap && o_status[13]);
  cover property (o_soft_break_trap);
endmodule

bind breakpoint_debug_status bds_asserts u_chk (.i_mclk(i_mclk), .i_reset_n(i_reset_n),
  .i_txn_debug(i_txn_debug), .i_real_mode(i_real_mode), .i_mgmt_state(i_mgmt_state),
  .i_priv_level(i_priv_level), .i_ext_flag(i_ext_flag), .i_mov_req(i_mov_req),
  .i_mov_write(i_mov_write), .i_mov_slot(i_mov_slot), .i_insn_done(i_insn_done),
  .i_step_flag(i_step_flag), .i_task_switch(i_task_switch), .i_task_trap(i_task_trap),
  .i_soft_break(i_soft_break), .o_mov_done(o_mov_done), .o_debug_trap(o_debug_trap),
  .o_soft_break_trap(o_soft_break_trap), .o_status(o_status));

// file: tb/tb_top.sv
// self-checking bench for the debug status block
// assumes dbg_pkg is compiled first; bench drives every port itself
module tb_top;
  timeunit 1ns;
  timeprecision 1ns;
  import dbg_pkg::*;
  logic        i_mclk, i_reset_n, i_real_mode, i_mgmt_state, i_ext_flag, i_txn_debug;
  logic        i_mov_req, i_mov_write, i_acc_valid, i_insn_done, i_step_flag, i_resume_flag;
  logic        i_task_switch, i_task_trap, i_soft_break;
  logic [1:0]  i_priv_level, i_acc_kind;
  logic [2:0]  i_mov_slot;
  logic [3:0]  i_acc_len;
  logic [31:0] i_mov_wdata, i_acc_addr, o_mov_rdata, o_status;
  logic        o_mov_done, o_prot_fault, o_bad_opcode, o_debug_trap, o_soft_break_trap;
  int          failures, n_compared, cycles;
  breakpoint_debug_status dut (.i_mclk, .i_reset_n, .i_real_mode, .i_mgmt_state,
    .i_priv_level, .i_ext_flag, .i_txn_debug, .i_mov_req, .i_mov_write, .i_mov_slot,
    .i_mov_wdata, .i_acc_valid, .i_acc_kind, .i_acc_addr, .i_acc_len, .i_insn_done,
    .i_step_flag, .i_resume_flag, .i_task_switch, .i_task_trap, .i_soft_break, .o_mov_done,
    .o_mov_rdata, .o_prot_fault, .o_bad_opcode, .o_debug_trap, .o_soft_break_trap, .o_status);
  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
    n_compared++;
    if (got !== exp) begin
      failures++;
      $display("MISMATCH %s expected %h seen %h", what, exp, got);
    end
  endtask
  // one-cycle pulse; results are settled when it returns
  task automatic fire(ref logic s);
    @(posedge i_mclk);
    #1;
    s = 1'b1;
    @(posedge i_mclk);
    #1;
    s = 1'b0;
  endtask
  task automatic mov(input logic wr, input logic [2:0] slot, input logic [31:0] d);
    i_mov_write = wr;
    i_mov_slot  = slot;
    i_mov_wdata = d;
    fire(i_mov_req);
  endtask
  task automatic acc(input logic [1:0] kind, input logic [31:0] a, input logic [3:0] len);
    i_acc_kind = kind;
    i_acc_addr = a;
    i_acc_len  = len;
    fire(i_acc_valid);
  endtask
  task automatic report_and_stop;
    $display("compared %0d mismatches %0d", n_compared, failures);
    if (failures == 0 && n_compared > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask
  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_regs;
    chk("status rst", STATUS_RST, o_status);
    mov(1'b0, SLOT_FOUR, 32'h0);
    chk("alias four", STATUS_RST, o_mov_rdata);
    mov(1'b0, SLOT_FIVE, 32'h0);
    chk("alias five", CTRL_RST, o_mov_rdata);
    mov(1'b1, SLOT_ADDR3, 32'hA5A55A5C);
    mov(1'b0, SLOT_ADDR3, 32'h0);
    chk("addr3", 32'hA5A55A5C, o_mov_rdata);
    $display("t_regs done");
  endtask
  task automatic t_faults;
    i_priv_level = 2'h3;
    mov(1'b0, SLOT_ADDR0, 32'h0);
    chk("prot", 32'h1, {31'h0, o_prot_fault});
    chk("no done", 32'h0, {31'h0, o_mov_done});
    i_real_mode = 1'b1;
    mov(1'b0, SLOT_ADDR0, 32'h0);
    chk("real done", 32'h1, {31'h0, o_mov_done});
    i_real_mode  = 1'b0;
    i_priv_level = PRIV_TOP;
    i_ext_flag   = 1'b1;
    mov(1'b0, SLOT_FOUR, 32'h0);
    chk("bad op", 32'h1, {31'h0, o_bad_opcode});
    i_ext_flag = 1'b0;
    $display("t_faults done");
  endtask
  task automatic t_break;
    mov(1'b1, SLOT_ADDR0, 32'h000A0001);
    mov(1'b1, SLOT_CTRL, 32'h00010001);
    acc(KIND_WRITE, 32'h000A0001, 4'h1);
    chk("bp trap", 32'h1, {31'h0, o_debug_trap});
    chk("bp status", 32'hFFFF0FF1, o_status);
    acc(KIND_RDWR, 32'h000A0001, 4'h1);
    chk("read miss", 32'h0, {31'h0, o_debug_trap});
    acc(KIND_WRITE, 32'h000A0000, 4'h2);
    chk("span hit", 32'h1, {31'h0, o_debug_trap});
    $display("t_break done");
  endtask
  task automatic t_events;
    mov(1'b1, SLOT_CTRL, 32'h00010801);
    i_step_flag = 1'b1;
    i_txn_debug = 1'b1;
    fire(i_insn_done);
    chk("step status", 32'hFFFE4FF0, o_status);
    i_step_flag = 1'b0;
    i_txn_debug = 1'b0;
    i_task_trap = 1'b1;
    fire(i_task_switch);
    chk("task status", 32'hFFFFCFF0, o_status);
    i_task_trap = 1'b0;
    mov(1'b0, SLOT_CTRL, 32'h0);
    chk("local clear", 32'h0, o_mov_rdata & 32'h00000001);
    mov(1'b1, SLOT_CTRL, 32'h00002000);
    mov(1'b0, SLOT_ADDR0, 32'h0);
    chk("guard trap", 32'h1, {31'h0, o_debug_trap & ~o_mov_done});
    chk("guard status", 32'hFFFFEFF0, o_status);
    mov(1'b0, SLOT_CTRL, 32'h0);
    chk("guard clear", 32'h0, o_mov_rdata & 32'h00002000);
    fire(i_soft_break);
    chk("soft break", 32'h1, {31'h0, o_soft_break_trap});
    mov(1'b1, SLOT_STATUS, STATUS_RST);
    chk("status clear", STATUS_RST, o_status);
    $display("t_events done");
  endtask
  // ------------------------------------------------------------
  // clock, watchdog, main sequence
  // ------------------------------------------------------------
  initial begin
    i_mclk = 1'b0;
    forever #25 i_mclk = ~i_mclk;
  end
  always @(posedge i_mclk) begin
    cycles++;
    if (cycles == 2000) begin
      failures++;
      report_and_stop();
    end
  end
  initial begin
    {i_reset_n, i_real_mode, i_mgmt_state, i_ext_flag, i_txn_debug, i_mov_req} = '0;
    {i_mov_write, i_acc_valid, i_insn_done, i_step_flag, i_resume_flag} = '0;
    {i_task_switch, i_task_trap, i_soft_break, i_priv_level, i_acc_kind} = '0;
    {i_mov_slot, i_acc_len, i_mov_wdata, i_acc_addr} = '0;
    repeat (16) @(posedge i_mclk);
    #1;
    i_reset_n = 1'b1;
    repeat (3) @(posedge i_mclk);
    t_regs();
    t_faults();
    t_break();
    t_events();
    report_and_stop();
  end
endmodule
